// ===== common/ldo_power_pkg.sv
`default_nettype none
package ldo_power_pkg;
   localparam logic [15:0] pmgt_offset = 16'h1930;
   localparam logic [15:0] ldo_offset = 16'h7004;
   localparam int clkout_bit = 0;
   localparam int light_shut_bit = 1;
   localparam int full_shut_bit = 2;
   localparam int wake_dir_bit = 3;
   localparam int wake_out_bit = 4;
   localparam logic [4:0] pmgt_reset = 5'h10;
   localparam int usb_en_bit = 0;
   localparam int volt_low_bit = 1;
   localparam logic [1:0] ldo_reset = 2'h0;
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;

   typedef struct packed {
      logic ana;
      logic core;
      logic usb;
   } reg_en_t;

   typedef struct packed {
      logic [4:0] pmgt;
      logic [1:0] ldo;
      logic strap_meta;
      logic strap_sync;
      logic wake_meta;
      logic wake_sync;
      reg_en_t en;
      logic bandgap_en;
      logic por_en;
      logic aw_got;
      logic [15:0] awaddr;
      logic w_got;
      logic [15:0] wdata;
      logic [1:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [15:0] rdata;
      logic [1:0] rresp;
   } ldo_state_t;
endpackage
`default_nettype wire

// ===== src/ldo_power_control.sv
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module ldo_power_control
   import ldo_power_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write address
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // Write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // Write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read address
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // Read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pins and wake sources
   input wire logic core_regulator_strap,
   input wire logic wake_pin_i,
   output logic wake_pin_o,
   output logic wake_pin_oe,
   input wire logic rtc_alarm,
   // Regulator and clock controls
   output reg_en_t reg_en,
   output reg_en_t reg_drive_en,
   output logic bandgap_en,
   output logic por_en,
   output logic core_voltage_low,
   output logic rtc_clock_out_enable
);

   ldo_state_t q, d;
   logic shut;
   logic wake_ev;
   logic wr_fire;
   logic rd_fire;
   logic wr_pmgt;
   logic wr_ldo;

   function automatic logic [15:0] merge16(
      input logic [15:0] old,
      input logic [15:0] data,
      input logic [1:0] strb
   );
      logic [15:0] r;
      r = old;
      if (strb[0]) begin
         r[7:0] = data[7:0];
      end
      if (strb[1]) begin
         r[15:8] = data[15:8];
      end
      return r;
   endfunction

   assign shut = q.pmgt[light_shut_bit] | q.pmgt[full_shut_bit];
   // Wake pin counts only while configured as an input
   assign wake_ev = (q.wake_sync & ~q.pmgt[wake_dir_bit]) | rtc_alarm;
   assign wr_fire = q.aw_got & q.w_got & ~q.bvalid;
   assign rd_fire = s_axi_arvalid & s_axi_arready;
   assign wr_pmgt = wr_fire & (q.awaddr == pmgt_offset);
   assign wr_ldo = wr_fire & (q.awaddr == ldo_offset);

   always_comb begin
      logic [15:0] m;
      logic [4:0] p;
      m = 16'h0000;
      p = q.pmgt;
      d = q;
      // Pins are asynchronous; only the second stage feeds logic
      d.strap_meta = core_regulator_strap;
      d.strap_sync = q.strap_meta;
      d.wake_meta = wake_pin_i;
      d.wake_sync = q.wake_meta;
      // Wake clears the shutdown bits; a same-cycle write wins
      if (shut && wake_ev) begin
         p[light_shut_bit] = 1'b0;
         p[full_shut_bit] = 1'b0;
      end
      // Write channel: address and data may arrive in either order
      if (s_axi_awvalid && s_axi_awready) begin
         d.aw_got = 1'b1;
         d.awaddr = {s_axi_awaddr[15:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
         d.w_got = 1'b1;
         d.wdata = s_axi_wdata[15:0];
         d.wstrb = s_axi_wstrb[1:0];
      end
      if (wr_fire) begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = (wr_pmgt || wr_ldo) ? resp_okay : resp_slverr;
      end
      if (wr_pmgt) begin
         m = merge16({11'h000, q.pmgt}, q.wdata, q.wstrb);
         p = m[4:0];
      end
      if (wr_ldo) begin
         m = merge16({14'h0000, q.ldo}, q.wdata, q.wstrb);
         d.ldo = m[1:0];
      end
      d.pmgt = p;
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      // Read channel
      if (rd_fire) begin
         d.rvalid = 1'b1;
         d.rresp = resp_okay;
         if ({s_axi_araddr[15:2], 2'b00} == pmgt_offset) begin
            d.rdata = {11'h000, q.pmgt};
         end else if ({s_axi_araddr[15:2], 2'b00} == ldo_offset) begin
            d.rdata = {14'h0000, q.ldo};
         end else begin
            d.rdata = 16'h0000;
            d.rresp = resp_slverr;
         end
      end else if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      // Enables follow the next control state, so they track it in step
      d.en.ana = ~(p[light_shut_bit] | p[full_shut_bit]);
      d.en.core = d.en.ana & ~q.strap_sync;
      d.en.usb = d.en.ana & d.ldo[usb_en_bit];
      d.bandgap_en = ~p[full_shut_bit];
      d.por_en = d.en.ana;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.pmgt <= pmgt_reset;
         q.ldo <= ldo_reset;
         // Synchronisers keep running so the strap is settled at release
         q.strap_meta <= d.strap_meta;
         q.strap_sync <= d.strap_sync;
         q.wake_meta <= d.wake_meta;
         q.wake_sync <= d.wake_sync;
         // Analog stays on through reset; core never blips on a high strap
         q.en.ana <= 1'b1;
         q.en.core <= ~q.strap_sync;
         q.en.usb <= 1'b0;
         q.bandgap_en <= 1'b1;
         q.por_en <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Bus handshakes
   assign s_axi_awready = ~q.aw_got & ~q.bvalid;
   assign s_axi_wready = ~q.w_got & ~q.bvalid;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = ~q.rvalid;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rresp = q.rresp;
   assign s_axi_rdata = {16'h0000, q.rdata};

   // Regulator controls; a regulator's pin drives only while enabled
   assign reg_en = q.en;
   assign reg_drive_en = q.en;
   assign bandgap_en = q.bandgap_en;
   assign por_en = q.por_en;
   assign core_voltage_low = q.ldo[volt_low_bit];
   assign rtc_clock_out_enable = q.pmgt[clkout_bit];
   // Open drain: only a low level is ever driven
   assign wake_pin_o = 1'b0;
   assign wake_pin_oe = q.pmgt[wake_dir_bit] & ~q.pmgt[wake_out_bit];

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_write_ldo;
      wr_ldo && q.wstrb[0];
   endsequence

   sequence s_shut_seen;
      shut ##1 !shut;
   endsequence

   chk_shut_all: assert property (
      shut |-> !reg_en.ana && !reg_en.core && !reg_en.usb)
      else $error("regulator on during shutdown");

   chk_wake_cause: assert property (
      s_shut_seen |-> $past(wake_ev) || $past(wr_pmgt))
      else $error("shutdown left without a wake event");

   chk_ana_on: assert property (
      !shut |-> reg_en.ana && por_en)
      else $error("analog regulator off without shutdown");

   chk_core_strap: assert property (
      ##1 !shut && $past(!shut) |-> (reg_en.core == !$past(q.strap_sync)))
      else $error("core enable does not follow strap");

   chk_volt_write: assert property (
      s_write_ldo |=> core_voltage_low == $past(q.wdata[volt_low_bit]))
      else $error("core voltage select not updated");

   chk_usb_follow: assert property (
      !shut |-> reg_en.usb == q.ldo[usb_en_bit])
      else $error("usb regulator does not follow its bit");

   chk_drive_hiz: assert property (
      reg_drive_en == reg_en)
      else $error("disabled regulator pin driven");

   chk_read_zero: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:5] == 27'h0000000)
      else $error("reserved read bits not zero");

   chk_wake_oe: assert property (
      q.pmgt[wake_dir_bit] && !q.pmgt[wake_out_bit] |-> wake_pin_oe && !wake_pin_o)
      else $error("wake pin not driven low");

   chk_bandgap: assert property (
      (q.pmgt[light_shut_bit] && !q.pmgt[full_shut_bit]) |-> bandgap_en)
      else $error("light shutdown stopped bandgap");

   chk_full_off: assert property (
      q.pmgt[full_shut_bit] |-> !bandgap_en && !por_en)
      else $error("full shutdown left bandgap on");

   chk_clkout: assert property (
      wr_pmgt && q.wstrb[0] |=> rtc_clock_out_enable == $past(q.wdata[clkout_bit]))
      else $error("clock output enable not updated");

   chk_resp_time: assert property (
      wr_fire |=> s_axi_bvalid)
      else $error("write response late");

   sequence s_wake_hit;
      shut && wake_ev && !wr_pmgt;
   endsequence

   sequence s_read_pmgt;
      rd_fire && ({s_axi_araddr[15:2], 2'b00} == pmgt_offset);
   endsequence

   chk_wake_clear: assert property (
      s_wake_hit |=> !shut)
      else $error("wake event did not end shutdown");

   chk_shut_hold: assert property (
      shut && !wake_ev && !wr_pmgt |=> shut)
      else $error("shutdown ended without a wake event");

   chk_pin_dir: assert property (
      shut && q.pmgt[wake_dir_bit] && !rtc_alarm && !wr_pmgt |=> shut)
      else $error("wake pin woke while set as output");

   chk_strap_off: assert property (
      q.strap_sync |=> !reg_en.core)
      else $error("core regulator on with strap high");

   chk_usb_write: assert property (
      s_write_ldo |=> reg_en.usb == ($past(q.wdata[usb_en_bit]) && !shut))
      else $error("usb regulator not switched by write");

   chk_volt_hold: assert property (
      !wr_ldo |=> $stable(core_voltage_low))
      else $error("core voltage select changed without write");

   chk_reset_volt: assert property (
      $rose(aresetn) |-> !core_voltage_low && !reg_en.usb)
      else $error("reset left core voltage low or usb on");

   chk_reset_pmgt: assert property (
      $rose(aresetn) |-> q.pmgt == pmgt_reset)
      else $error("power management reset value wrong");

   chk_pmgt_write: assert property (
      wr_pmgt && q.wstrb[0] |=> q.pmgt == $past(q.wdata[4:0]))
      else $error("power management write not stored");

   chk_read_pmgt: assert property (
      s_read_pmgt |=> s_axi_rdata == {27'h0000000, $past(q.pmgt)})
      else $error("power management read data wrong");

   chk_wake_release: assert property (
      q.pmgt[wake_out_bit] |-> !wake_pin_oe)
      else $error("wake pin driven while released");

   chk_clkout_hold: assert property (
      !wr_pmgt |=> $stable(rtc_clock_out_enable))
      else $error("clock output enable changed without write");

endmodule // ldo_power_control
`default_nettype wire

// ===== tb/ldo_board.sv
`timescale 1ns/1ps
`default_nettype none
module ldo_board (
   // Board controls
   input wire logic ext_high,
   input wire logic strap_high,
   // Device pins
   input wire logic wake_pin_o,
   input wire logic wake_pin_oe,
   output logic wake_pin_i,
   output logic core_regulator_strap
);
   // Open drain wins over the external source while enabled
   assign wake_pin_i = wake_pin_oe ? wake_pin_o : ext_high;
   assign core_regulator_strap = strap_high;
endmodule // ldo_board
`default_nettype wire

// ===== tb/tb_ldo_power_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ldo_power_control
   import ldo_power_pkg::*;
;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [15:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [1:0] bresp, rresp, rs;
   logic ext_high, strap_high, strap, wk_i, wk_o, wk_oe, alarm, bg, por, vlow, ckout;
   reg_en_t en, drv;
   int failures, checks;

   ldo_power_control dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .core_regulator_strap(strap), .wake_pin_i(wk_i),
      .wake_pin_o(wk_o), .wake_pin_oe(wk_oe), .rtc_alarm(alarm), .reg_en(en),
      .reg_drive_en(drv), .bandgap_en(bg), .por_en(por), .core_voltage_low(vlow),
      .rtc_clock_out_enable(ckout));
   ldo_board board_u (.ext_high(ext_high), .strap_high(strap_high), .wake_pin_o(wk_o),
      .wake_pin_oe(wk_oe), .wake_pin_i(wk_i), .core_regulator_strap(strap));

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   // Handshakes are judged at the falling edge, where inputs and outputs are settled
   task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw, w, b;
      b = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b) begin
         @(negedge aclk);
         aw = awvalid && awready;
         w = wvalid && wready;
         b = bvalid;
         r = bresp;
         @(posedge aclk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      @(negedge aclk);
   endtask

   task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      logic x, got;
      got = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!got) begin
         @(negedge aclk);
         x = arready;
         got = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (x) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      @(negedge aclk);
   endtask

   task automatic rst(input logic s);
      @(posedge aclk);
      aresetn <= 1'b0;
      strap_high <= s;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(negedge aclk);
   endtask

   task automatic pin(input logic l);
      @(posedge aclk);
      ext_high <= l;
      repeat (6) @(negedge aclk);
   endtask

   task automatic conclude;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, ext_high, strap_high, alarm} = '0;
      {awaddr, araddr, wdata} = '0;
      rst(1'b0);
      chk("reg_en", 32'h6, 32'(en));
      chk("drive_en", 32'h6, 32'(drv));
      rd(pmgt_offset, v, rs);
      chk("pmgt", 32'h10, v);
      rd(ldo_offset, v, rs);
      chk("ldo", 32'h0, v);
      chk("vlow", 32'h0, 32'(vlow));
      wr(ldo_offset, 32'h3, rs);
      chk("reg_en", 32'h7, 32'(en));
      chk("vlow", 32'h1, 32'(vlow));
      wr(pmgt_offset, 32'hffff, rs);
      chk("reg_en", 32'h0, 32'(en));
      chk("drive_en", 32'h0, 32'(drv));
      chk("bandgap", 32'h0, 32'(bg));
      chk("por", 32'h0, 32'(por));
      chk("clk_out", 32'h1, 32'(ckout));
      chk("wake_oe", 32'h0, 32'(wk_oe));
      // Pin is an output here, so a high level must not wake
      pin(1'b1);
      rd(pmgt_offset, v, rs);
      chk("pmgt", 32'h1f, v);
      pin(1'b0);
      wr(pmgt_offset, 32'h0a, rs);
      chk("wake_oe", 32'h1, 32'(wk_oe));
      chk("wake_o", 32'h0, 32'(wk_o));
      chk("bandgap", 32'h1, 32'(bg));
      wr(pmgt_offset, 32'h12, rs);
      pin(1'b1);
      chk("reg_en", 32'h7, 32'(en));
      rd(pmgt_offset, v, rs);
      chk("pmgt", 32'h10, v);
      pin(1'b0);
      wr(pmgt_offset, 32'h14, rs);
      chk("reg_en", 32'h0, 32'(en));
      @(posedge aclk);
      alarm <= 1'b1;
      @(posedge aclk);
      alarm <= 1'b0;
      repeat (3) @(negedge aclk);
      chk("reg_en", 32'h7, 32'(en));
      rd(16'h0100, v, rs);
      chk("rresp", 32'(resp_slverr), 32'(rs));
      wr(16'h0100, 32'h0, rs);
      chk("bresp", 32'(resp_slverr), 32'(rs));
      rst(1'b1);
      chk("reg_en", 32'h4, 32'(en));
      chk("vlow", 32'h0, 32'(vlow));
      conclude;
   end

   initial begin
      repeat (3000) @(posedge aclk);
      failures++;
      conclude;
   end
endmodule // tb_ldo_power_control
`default_nettype wire
